/* File: pkg/alu_cfg.svh */
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// register byte offsets
`define OFF_CMD 8'h00
`define OFF_ACC 8'h04
`define OFF_STATUS 8'h08
`define OFF_DIR6 8'h0c
`define OFF_DIR7 8'h10
`define OFF_RESULT 8'h14

// command word fields
`define CMD_OP_LSB 0
`define CMD_DEST_BIT 3
`define CMD_FADDR_LSB 4
`define CMD_LIT_LSB 16

// status word fields
`define ST_CARRY_BIT 0
`define ST_NIBBLE_BIT 1
`define ST_ZERO_BIT 2
`define ST_BUSY_BIT 3

// direction register selectors
`define DIR_SEL_LO 5'h06
`define DIR_SEL_HI 5'h07

// reset values
`define ACC_RST 8'h00
`define DIR_RST 8'hff
`define RESULT_RST 8'h00
`define FLAG_RST 1'b0

`endif

/* File: pkg/alu_pkg.sv */
package alu_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SUB = 3'b001,
        OP_RRC = 3'b010,
        OP_SWAP = 3'b011,
        OP_DIR = 3'b100,
        OP_XORF = 3'b101,
        OP_XORL = 3'b110
    } op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } state_t;

endpackage

/* File: logic/byte_alu.sv */
`timescale 1ns/1ps
`include "alu_cfg.svh"

// Notes on behaviour
// [RULE1] Subtract computes file value minus accumulator and updates carry, nibble carry and zero.
// [RULE2] Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// [RULE3] Rotate right moves carry into bit 7 and bit 0 into carry, touching only carry.
// [RULE4] Nibble exchange swaps the two halves of the file value and leaves every flag alone.
// [RULE5] Direction load copies the accumulator into direction register 6 or 7, flags untouched.
// [RULE6] Xor with file combines accumulator and file value, routes by destination, updates only zero.
// [RULE7] Xor with literal combines accumulator and an 8-bit literal into the accumulator, only zero changes.
// [RULE8] Zero is set when the 8-bit result is zero and cleared otherwise, whenever it is affected.
module byte_alu (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] file_rd_data,
    output logic [4:0] file_addr,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    output logic [7:0] dir_port6,
    output logic [7:0] dir_port7
);
    import alu_pkg::*;

    state_t state_r, state_nxt;
    alu_pkg::op_t op_r, op_nxt;
    logic dest_r, dest_nxt;
    logic [4:0] faddr_r, faddr_nxt;
    logic [7:0] lit_r, lit_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] dir6_r, dir6_nxt;
    logic [7:0] dir7_r, dir7_nxt;
    logic carry_r, carry_nxt;
    logic nibble_r, nibble_nxt;
    logic zero_r, zero_nxt;
    logic dphase_r, dphase_nxt;
    logic dwrite_r, dwrite_nxt;
    logic [7:0] daddr_r, daddr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_en_r, wr_en_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic [8:0] diff9;
    logic [4:0] diff5;
    logic [7:0] res;
    logic res_valid;
    logic [31:0] status_word;

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign file_addr = faddr_r;
    assign file_wr_en = wr_en_r;
    assign file_wr_data = wr_data_r;
    assign dir_port6 = dir6_r;
    assign dir_port7 = dir7_r;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ST_CARRY_BIT] = carry_r;
        status_word[`ST_NIBBLE_BIT] = nibble_r;
        status_word[`ST_ZERO_BIT] = zero_r;
        status_word[`ST_BUSY_BIT] = (state_r == ST_EXEC);
    end

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        dest_nxt = dest_r;
        faddr_nxt = faddr_r;
        lit_nxt = lit_r;
        acc_nxt = acc_r;
        result_nxt = result_r;
        dir6_nxt = dir6_r;
        dir7_nxt = dir7_r;
        carry_nxt = carry_r;
        nibble_nxt = nibble_r;
        zero_nxt = zero_r;
        dphase_nxt = dphase_r;
        dwrite_nxt = dwrite_r;
        daddr_nxt = daddr_r;
        rdata_nxt = rdata_r;
        wr_en_nxt = 1'b0;
        wr_data_nxt = wr_data_r;
        diff9 = {1'b0, file_rd_data} - {1'b0, acc_r};
        diff5 = {1'b0, file_rd_data[3:0]} - {1'b0, acc_r[3:0]};
        res = result_r;
        res_valid = 1'b0;
        if (!ce) begin
            wr_en_nxt = wr_en_r;
        end else begin
            // bus data phase
            if (dphase_r && dwrite_r) begin
                case (daddr_r)
                    `OFF_CMD: begin
                        op_nxt = alu_pkg::op_t'(hwdata[`CMD_OP_LSB +: 3]);
                        dest_nxt = hwdata[`CMD_DEST_BIT];
                        faddr_nxt = hwdata[`CMD_FADDR_LSB +: 5];
                        lit_nxt = hwdata[`CMD_LIT_LSB +: 8];
                        state_nxt = ST_EXEC;
                    end
                    `OFF_ACC: acc_nxt = hwdata[7:0];
                    `OFF_STATUS: begin
                        carry_nxt = hwdata[`ST_CARRY_BIT];
                        nibble_nxt = hwdata[`ST_NIBBLE_BIT];
                        zero_nxt = hwdata[`ST_ZERO_BIT];
                    end
                    default: ;
                endcase
            end
            // bus address phase
            dphase_nxt = hsel && htrans[1] && hready;
            if (hsel && htrans[1] && hready) begin
                dwrite_nxt = hwrite;
                daddr_nxt = haddr[7:0];
                case (haddr[7:0])
                    `OFF_ACC: rdata_nxt = {24'h000000, acc_r};
                    `OFF_STATUS: rdata_nxt = status_word;
                    `OFF_DIR6: rdata_nxt = {24'h000000, dir6_r};
                    `OFF_DIR7: rdata_nxt = {24'h000000, dir7_r};
                    `OFF_RESULT: rdata_nxt = {24'h000000, result_r};
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
            // execution of the latched command, wins over bus writes except a command write, which keeps ST_EXEC
            if (state_r == ST_EXEC) begin
                if (!(dphase_r && dwrite_r && daddr_r == `OFF_CMD)) begin
                    state_nxt = ST_IDLE;
                end
                case (op_r)
                    OP_SUB: begin
                        res = diff9[7:0]; // RULE1
                        carry_nxt = ~diff9[8]; // RULE1
                        nibble_nxt = ~diff5[4]; // RULE1
                        zero_nxt = (diff9[7:0] == 8'h00); // RULE8
                        res_valid = 1'b1;
                    end
                    OP_RRC: begin
                        res = {carry_r, file_rd_data[7:1]}; // RULE3
                        carry_nxt = file_rd_data[0]; // RULE3
                        res_valid = 1'b1;
                    end
                    OP_SWAP: begin
                        res = {file_rd_data[3:0], file_rd_data[7:4]}; // RULE4
                        res_valid = 1'b1;
                    end
                    OP_DIR: begin
                        if (faddr_r == `DIR_SEL_LO) begin
                            dir6_nxt = acc_r; // RULE5
                        end else if (faddr_r == `DIR_SEL_HI) begin
                            dir7_nxt = acc_r; // RULE5
                        end
                    end
                    OP_XORF: begin
                        res = acc_r ^ file_rd_data; // RULE6
                        zero_nxt = ((acc_r ^ file_rd_data) == 8'h00); // RULE8
                        res_valid = 1'b1;
                    end
                    OP_XORL: begin
                        res = acc_r ^ lit_r; // RULE7
                        zero_nxt = ((acc_r ^ lit_r) == 8'h00); // RULE8
                        acc_nxt = acc_r ^ lit_r; // RULE7
                        result_nxt = acc_r ^ lit_r;
                    end
                    default: ;
                endcase
                if (res_valid) begin
                    result_nxt = res;
                    if (dest_r) begin
                        wr_en_nxt = 1'b1; // RULE2
                        wr_data_nxt = res; // RULE2
                    end else begin
                        acc_nxt = res; // RULE2
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            op_r <= OP_NONE;
            dest_r <= 1'b0;
            faddr_r <= 5'h00;
            lit_r <= 8'h00;
            acc_r <= `ACC_RST;
            result_r <= `RESULT_RST;
            dir6_r <= `DIR_RST;
            dir7_r <= `DIR_RST;
            carry_r <= `FLAG_RST;
            nibble_r <= `FLAG_RST;
            zero_r <= `FLAG_RST;
            dphase_r <= 1'b0;
            dwrite_r <= 1'b0;
            daddr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            wr_en_r <= 1'b0;
            wr_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            dest_r <= dest_nxt;
            faddr_r <= faddr_nxt;
            lit_r <= lit_nxt;
            acc_r <= acc_nxt;
            result_r <= result_nxt;
            dir6_r <= dir6_nxt;
            dir7_r <= dir7_nxt;
            carry_r <= carry_nxt;
            nibble_r <= nibble_nxt;
            zero_r <= zero_nxt;
            dphase_r <= dphase_nxt;
            dwrite_r <= dwrite_nxt;
            daddr_r <= daddr_nxt;
            rdata_r <= rdata_nxt;
            wr_en_r <= wr_en_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence quiet_exec_s;
        ce && state_r == ST_EXEC && !(dphase_r && dwrite_r);
    endsequence

    sequence sub_step_s;
        quiet_exec_s ##0 op_r == OP_SUB;
    endsequence

    sub_result_a: assert property ( // RULE1
        sub_step_s |=> result_r == $past(file_rd_data) - $past(acc_r)
            && carry_r == ($past(file_rd_data) >= $past(acc_r))
            && nibble_r == ($past(file_rd_data[3:0]) >= $past(acc_r[3:0])))
        else $error("subtract result or flags wrong");

    dest_route_a: assert property ( // RULE2
        quiet_exec_s ##0 op_r == OP_XORF
            |=> (file_wr_en == $past(dest_r))
            && (file_wr_en ? acc_r == $past(acc_r) : acc_r == result_r))
        else $error("result sent to wrong destination");

    rotate_carry_a: assert property ( // RULE3
        quiet_exec_s ##0 op_r == OP_RRC
            |=> result_r == {$past(carry_r), $past(file_rd_data[7:1])}
            && carry_r == $past(file_rd_data[0]) && $stable(zero_r)
            && $stable(nibble_r))
        else $error("rotate result or carry wrong");

    swap_nibbles_a: assert property ( // RULE4
        quiet_exec_s ##0 op_r == OP_SWAP
            |=> result_r == {$past(file_rd_data[3:0]),
                $past(file_rd_data[7:4])}
            && $stable(carry_r) && $stable(nibble_r) && $stable(zero_r))
        else $error("swap result wrong or flag moved");

    dir_load_a: assert property ( // RULE5
        quiet_exec_s ##0 op_r == OP_DIR ##0 faddr_r == `DIR_SEL_LO
            |=> dir_port6 == $past(acc_r) && $stable(dir_port7)
            && $stable(carry_r) && $stable(zero_r))
        else $error("direction register 6 not loaded");

    xor_file_a: assert property ( // RULE6
        quiet_exec_s ##0 op_r == OP_XORF
            |=> result_r == ($past(acc_r) ^ $past(file_rd_data))
            && $stable(carry_r) && $stable(nibble_r))
        else $error("xor with file wrong");

    xor_literal_a: assert property ( // RULE7
        quiet_exec_s ##0 op_r == OP_XORL
            |=> acc_r == ($past(acc_r) ^ $past(lit_r)) && !file_wr_en
            && $stable(carry_r))
        else $error("xor with literal wrong");

    zero_flag_a: assert property ( // RULE8
        quiet_exec_s ##0 (op_r == OP_SUB || op_r == OP_XORF
            || op_r == OP_XORL) |=> zero_r == (result_r == 8'h00))
        else $error("zero flag does not match result");

endmodule

/* File: tb/file_store_model.sv */
`timescale 1ns/1ps
module file_store_model (
    input wire logic clk_sys,
    input wire logic [4:0] file_addr,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data,
    output logic [7:0] file_rd_data
);
    logic [7:0] mem [32];
    // read path is combinational, like the real storage
    assign file_rd_data = mem[file_addr];
    always @(posedge clk_sys) begin
        if (file_wr_en === 1'b1) begin
            mem[file_addr] <= file_wr_data;
        end
    end
endmodule

/* File: tb/tb_byte_alu_instruction_subset.sv */
`timescale 1ns/1ps
`include "alu_cfg.svh"
module tb_byte_alu_instruction_subset;
    import alu_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] res_e = 8'h00;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, file_wr_en;
    logic [31:0] hrdata;
    logic [7:0] file_rd_data, file_wr_data, dir_port6, dir_port7;
    logic [4:0] file_addr;
    logic [7:0] m [32];
    logic [7:0] w_e, d6_e, d7_e;
    logic c_e, dc_e, z_e;
    logic [31:0] rd;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #4 clk_sys = ~clk_sys;

    byte_alu u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .file_rd_data(file_rd_data), .file_addr(file_addr),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
        .dir_port6(dir_port6), .dir_port7(dir_port7));

    file_store_model u_file (.clk_sys(clk_sys), .file_addr(file_addr),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
        .file_rd_data(file_rd_data));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single word transfer, address phase then data phase
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic set_acc(input logic [7:0] v);
        xfer(`OFF_ACC, 1'b1, {24'h0, v}, rd);
        w_e = v;
    endtask

    task automatic run(input op_t op, input logic d, input logic [4:0] f,
                       input logic [7:0] lit);
        logic [7:0] fv;
        logic [7:0] r;
        fv = m[f];
        r = fv;
        case (op)
            OP_SUB: begin
                r = fv - w_e;
                c_e = (fv >= w_e);
                dc_e = (fv[3:0] >= w_e[3:0]);
                z_e = (r == 8'h00);
            end
            OP_RRC: begin
                r = {c_e, fv[7:1]};
                c_e = fv[0];
            end
            OP_SWAP: r = {fv[3:0], fv[7:4]};
            OP_DIR: begin
                if (f == 5'h06) d6_e = w_e;
                if (f == 5'h07) d7_e = w_e;
            end
            OP_XORF: begin
                r = fv ^ w_e;
                z_e = (r == 8'h00);
            end
            OP_XORL: begin
                r = w_e ^ lit;
                z_e = (r == 8'h00);
            end
            default: r = fv;
        endcase
        if (op inside {OP_SUB, OP_RRC, OP_SWAP, OP_XORF}) begin
            if (d) m[f] = r;
            else w_e = r;
        end
        if (op == OP_XORL) w_e = r;
        if (op inside {OP_SUB, OP_RRC, OP_SWAP, OP_XORF, OP_XORL}) res_e = r;
        xfer(`OFF_CMD, 1'b1, {8'h0, lit, 7'h0, f, d, op}, rd);
        repeat (2) @(posedge clk_sys);
        xfer(`OFF_ACC, 1'b0, 32'h0, rd);
        check("acc", rd, {24'h0, w_e});
        xfer(`OFF_STATUS, 1'b0, 32'h0, rd);
        check("status", rd, {28'h0, 1'b0, z_e, dc_e, c_e});
        xfer(`OFF_RESULT, 1'b0, 32'h0, rd);
        check("result", rd, {24'h0, res_e});
        check("file", {24'h0, u_file.mem[f]}, {24'h0, m[f]});
        check("dir6", {24'h0, dir_port6}, {24'h0, d6_e});
        check("dir7", {24'h0, dir_port7}, {24'h0, d7_e});
        check("resp", {31'h0, hresp}, 32'h0);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        for (int i = 0; i < 32; i++) begin
            m[i] = 8'(i * 37 + 11);
            u_file.mem[i] = m[i];
        end
        {w_e, c_e, dc_e, z_e} = 11'h0;
        d6_e = 8'hff;
        d7_e = 8'hff;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        xfer(8'h20, 1'b0, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        xfer(`OFF_ACC, 1'b0, 32'h0, rd);
        check("acc_rst", rd, {24'h0, `ACC_RST});
        xfer(`OFF_STATUS, 1'b0, 32'h0, rd);
        check("status_rst", rd, 32'h0);
        xfer(`OFF_DIR6, 1'b0, 32'h0, rd);
        check("dir6_rst", rd, {24'h0, `DIR_RST});
        xfer(`OFF_RESULT, 1'b0, 32'h0, rd);
        check("result_rst", rd, {24'h0, `RESULT_RST});
        set_acc(m[3]);
        run(OP_SUB, 1'b0, 5'd3, 8'h0);
        set_acc(8'hff);
        run(OP_SUB, 1'b1, 5'd5, 8'h0);
        set_acc(8'h0c);
        run(OP_SUB, 1'b1, 5'd9, 8'h0);
        xfer(`OFF_STATUS, 1'b1, 32'h1, rd);
        {z_e, dc_e, c_e} = 3'b001;
        run(OP_RRC, 1'b1, 5'd6, 8'h0);
        run(OP_RRC, 1'b0, 5'd7, 8'h0);
        run(OP_SWAP, 1'b1, 5'd4, 8'h0);
        run(OP_SWAP, 1'b0, 5'd9, 8'h0);
        run(OP_XORF, 1'b1, 5'd10, 8'h0);
        set_acc(m[11]);
        run(OP_XORF, 1'b0, 5'd11, 8'h0);
        run(OP_XORL, 1'b1, 5'd0, 8'hff);
        set_acc(8'h3c);
        run(OP_XORL, 1'b0, 5'd0, 8'h3c);
        set_acc(8'h12);
        run(OP_DIR, 1'b0, 5'd6, 8'h0);
        set_acc(8'h34);
        run(OP_DIR, 1'b0, 5'd7, 8'h0);
        run(OP_DIR, 1'b0, 5'd5, 8'h0);
        run(OP_NONE, 1'b1, 5'd12, 8'h0);
        run(op_t'(3'h7), 1'b1, 5'd13, 8'h0);
        // clock enable low holds the pending swap until it returns
        xfer(`OFF_CMD, 1'b1, {16'h0, 7'h0, 5'd20, 1'b0, OP_SWAP}, rd);
        ce <= 1'b0;
        @(posedge clk_sys);
        u_file.mem[20] = 8'h5a;
        m[20] = 8'h5a;
        repeat (2) @(posedge clk_sys);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        w_e = 8'ha5;
        xfer(`OFF_ACC, 1'b0, 32'h0, rd);
        check("acc_ce", rd, {24'h0, w_e});
        ce <= 1'b0;
        fork
            begin
                repeat (4) @(posedge clk_sys);
                ce <= 1'b1;
            end
            xfer(`OFF_ACC, 1'b0, 32'h0, rd);
        join
        check("acc_stall", rd, {24'h0, w_e});
        stop_test();
    end
endmodule
